// >>> hdl/ruc_top.sv
// Added by the designer: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module ruc_top #(
  parameter int PRE_CYC      = ruc_pkg::PRE_UPDATE_CYCLES,
  parameter int UPD_FAST_CYC = ruc_pkg::UPDATE_FAST_CYCLES,
  parameter int UPD_SLOW_CYC = ruc_pkg::UPDATE_SLOW_CYCLES
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        CLK_EN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        TIME_BASE_INPUT,
  input  wire logic        CLOCK_OUT_DIVIDE_SELECT,
  output logic             CLOCK_OUT_PIN,
  output logic             SQUARE_WAVE_PIN,
  output logic             IRQ_N
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (PRE_CYC < 1 || UPD_FAST_CYC < 1 || UPD_SLOW_CYC < 1
      || PRE_CYC >= 2**20 || UPD_FAST_CYC >= 2**20 || UPD_SLOW_CYC >= 2**20) begin : g_chk
    $error("update timing counts out of range");
  end

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  ruc_pkg::ruc_state_t state_reg;
  logic [19:0]         cnt_reg;
  logic [7:0]          sec_reg, min_reg, hour_reg, dow_reg, date_reg, month_reg, year_reg;
  logic [7:0]          asec_reg, amin_reg, ahour_reg;
  logic [7:0]          sec_next, min_next, hour_next, dow_next, date_next;
  logic [7:0]          month_next, year_next;
  logic [2:0]          dv_reg;
  logic [3:0]          rate_reg;
  logic                set_reg, pie_reg, aie_reg, uie_reg, sqwe_reg;
  logic                uf_reg, af_reg, periodic_flag_reg, update_in_progress_flag_reg;
  logic                pend_reg, wr_q;
  logic [5:0]          addr_q;
  logic                tick, pi_pulse;
  logic                run_ok, locked, do_update, alarm_hit;
  logic                wr_go, rd_go, irq_next;
  logic [19:0]         upd_cyc;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02:   month_days = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
      default: month_days = 8'h1f;
    endcase
  endfunction : month_days

  function automatic logic alarm_pos(input logic [7:0] a, input logic [7:0] t);
    alarm_pos = (a[7:6] == 2'h3) || (a == t);                       // [R4]
  endfunction : alarm_pos

  // ----------------------------------------------------------------------
  // divider, taps and clock out
  // ----------------------------------------------------------------------
  ruc_divider u_div (
    .clk                     (MCLK),
    .rst                     (RST),
    .en                      (CLK_EN),
    .tb_in                   (TIME_BASE_INPUT),
    .dv                      (dv_reg),
    .rate                    (rate_reg),
    .sqwe                    (sqwe_reg),
    .clock_out_divide_select (CLOCK_OUT_DIVIDE_SELECT),
    .tick                    (tick),
    .pi_pulse                (pi_pulse),
    .square_wave_pin         (SQUARE_WAVE_PIN),
    .clock_out_pin           (CLOCK_OUT_PIN)
  );

  // ----------------------------------------------------------------------
  // update sequencer
  // ----------------------------------------------------------------------
  // run only on a legal base with set clear
  assign run_ok    = ((dv_reg == ruc_pkg::DV_4M) || (dv_reg == ruc_pkg::DV_1M)
                     || (dv_reg == ruc_pkg::DV_32K)) && !set_reg;   // [R1]
  assign upd_cyc   = (dv_reg == ruc_pkg::DV_32K) ? 20'(UPD_SLOW_CYC)
                                                 : 20'(UPD_FAST_CYC); // [R5]
  assign locked    = (state_reg == ruc_pkg::UPD_RUN);
  assign do_update = locked && run_ok && (cnt_reg == 20'h0);

  // idle waits the 1 hz carry, pre holds the flag ahead, run blocks the bytes
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_reg <= ruc_pkg::UPD_IDLE;
      cnt_reg   <= 20'h0;
    end else if (CLK_EN) begin
      if (!run_ok) begin
        state_reg <= ruc_pkg::UPD_IDLE;                             // [R2] [R19]
      end else begin
        case (state_reg)
          ruc_pkg::UPD_IDLE: begin
            if (tick) begin                                         // [R1] [R18]
              state_reg <= ruc_pkg::UPD_PRE;
              cnt_reg   <= 20'(PRE_CYC - 1);                        // [R7]
            end
          end
          ruc_pkg::UPD_PRE: begin
            if (cnt_reg == 20'h0) begin
              state_reg <= ruc_pkg::UPD_RUN;
              cnt_reg   <= upd_cyc - 20'h1;                         // [R5]
            end else begin
              cnt_reg <= cnt_reg - 20'h1;
            end
          end
          ruc_pkg::UPD_RUN: begin
            if (cnt_reg == 20'h0) begin
              state_reg <= ruc_pkg::UPD_IDLE;
            end else begin
              cnt_reg <= cnt_reg - 20'h1;
            end
          end
          default: state_reg <= ruc_pkg::UPD_IDLE;
        endcase
      end
    end
  end

  // in-progress flag, high through pre and run
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      update_in_progress_flag_reg <= 1'b0;
    end else if (CLK_EN) begin
      update_in_progress_flag_reg <= run_ok && ((state_reg == ruc_pkg::UPD_PRE)
                                     || (state_reg == ruc_pkg::UPD_RUN && cnt_reg != 20'h0)
                                     || (state_reg == ruc_pkg::UPD_IDLE && tick)); // [R7] [R19]
    end
  end

  // ----------------------------------------------------------------------
  // time increment with carries
  // ----------------------------------------------------------------------
  always_comb begin
    sec_next   = sec_reg + 8'h01;
    min_next   = min_reg;
    hour_next  = hour_reg;
    dow_next   = dow_reg;
    date_next  = date_reg;
    month_next = month_reg;
    year_next  = year_reg;
    if (sec_next > 8'h3b) begin                                     // [R3]
      sec_next = 8'h00;
      min_next = min_reg + 8'h01;
      if (min_next > 8'h3b) begin
        min_next  = 8'h00;
        hour_next = hour_reg + 8'h01;
        if (hour_next > 8'h17) begin
          hour_next = 8'h00;
          dow_next  = (dow_reg >= 8'h07) ? 8'h01 : dow_reg + 8'h01;
          date_next = date_reg + 8'h01;
          if (date_next > month_days(month_reg, year_reg)) begin
            date_next  = 8'h01;
            month_next = month_reg + 8'h01;
            if (month_next > 8'h0c) begin
              month_next = 8'h01;
              year_next  = (year_reg >= 8'h63) ? 8'h00 : year_reg + 8'h01;
            end
          end
        end
      end
    end
  end

  assign alarm_hit = alarm_pos(asec_reg, sec_next) && alarm_pos(amin_reg, min_next)
                     && alarm_pos(ahour_reg, hour_next);            // [R4]

  // ----------------------------------------------------------------------
  // bus slave: address phase, one wait cycle, then data phase ends
  // ----------------------------------------------------------------------
  assign wr_go = pend_reg && wr_q;
  assign rd_go = pend_reg && !wr_q;

  // only a selected nonseq or seq transfer is taken
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pend_reg  <= 1'b0;
      wr_q      <= 1'b0;
      addr_q    <= 6'h0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (CLK_EN) begin
      if (pend_reg) begin
        pend_reg  <= 1'b0;
        HREADYOUT <= 1'b1;
      end else if (HSEL && HREADY && HTRANS[1]) begin               // [R12]
        pend_reg  <= 1'b1;
        wr_q      <= HWRITE;
        addr_q    <= HADDR[5:0];
        HREADYOUT <= 1'b0;
      end
    end
  end

  // read data, time bytes read as zero while off the bus
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      HRDATA <= 32'h0;
    end else if (CLK_EN && rd_go) begin
      HRDATA <= 32'h0;
      case (addr_q)
        ruc_pkg::OFS_SEC:     HRDATA[7:0] <= locked ? 8'h00 : sec_reg;   // [R6]
        ruc_pkg::OFS_ALM_SEC: HRDATA[7:0] <= locked ? 8'h00 : asec_reg;
        ruc_pkg::OFS_MIN:     HRDATA[7:0] <= locked ? 8'h00 : min_reg;
        ruc_pkg::OFS_ALM_MIN: HRDATA[7:0] <= locked ? 8'h00 : amin_reg;
        ruc_pkg::OFS_HOUR:    HRDATA[7:0] <= locked ? 8'h00 : hour_reg;
        ruc_pkg::OFS_ALM_HR:  HRDATA[7:0] <= locked ? 8'h00 : ahour_reg;
        ruc_pkg::OFS_DOW:     HRDATA[7:0] <= locked ? 8'h00 : dow_reg;
        ruc_pkg::OFS_DATE:    HRDATA[7:0] <= locked ? 8'h00 : date_reg;
        ruc_pkg::OFS_MONTH:   HRDATA[7:0] <= locked ? 8'h00 : month_reg;
        ruc_pkg::OFS_YEAR:    HRDATA[7:0] <= locked ? 8'h00 : year_reg;
        ruc_pkg::OFS_CTRL_A:  HRDATA[7:0] <= {update_in_progress_flag_reg, dv_reg, rate_reg};
        ruc_pkg::OFS_CTRL_B:  HRDATA[7:0] <= {set_reg, pie_reg, aie_reg, uie_reg,
                                              sqwe_reg, 3'h0};
        ruc_pkg::OFS_FLAGS:   HRDATA[7:0] <= {~IRQ_N, periodic_flag_reg, af_reg, uf_reg, 4'h0};
        default:              HRDATA <= 32'h0;
      endcase
    end
  end

  // control registers
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dv_reg   <= ruc_pkg::DV_RST_VALUE;
      rate_reg <= ruc_pkg::RATE_RST_VALUE;
      set_reg  <= 1'b0;
      pie_reg  <= 1'b0;
      aie_reg  <= 1'b0;
      uie_reg  <= 1'b0;
      sqwe_reg <= 1'b0;
    end else if (CLK_EN && wr_go) begin
      if (addr_q == ruc_pkg::OFS_CTRL_A) begin
        dv_reg <= HWDATA[ruc_pkg::A_DV_LO +: 3];                    // [R17]
        rate_reg <= HWDATA[3:0];                                    // [R15]
      end
      if (addr_q == ruc_pkg::OFS_CTRL_B) begin
        set_reg  <= HWDATA[ruc_pkg::B_SET];                         // [R2]
        pie_reg  <= HWDATA[ruc_pkg::B_PIE];
        aie_reg  <= HWDATA[ruc_pkg::B_AIE];
        uie_reg  <= HWDATA[ruc_pkg::B_UIE];
        sqwe_reg <= HWDATA[ruc_pkg::B_SQWE];                        // [R16]
      end
    end
  end

  // time and alarm bytes: update wins, bus writes refused while locked
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sec_reg   <= 8'h00;
      min_reg   <= 8'h00;
      hour_reg  <= 8'h00;
      dow_reg   <= ruc_pkg::DATE_RST_VALUE;
      date_reg  <= ruc_pkg::DATE_RST_VALUE;
      month_reg <= ruc_pkg::DATE_RST_VALUE;
      year_reg  <= 8'h00;
      asec_reg  <= 8'h00;
      amin_reg  <= 8'h00;
      ahour_reg <= 8'h00;
    end else if (CLK_EN) begin
      if (do_update) begin                                          // [R3]
        sec_reg   <= sec_next;
        min_reg   <= min_next;
        hour_reg  <= hour_next;
        dow_reg   <= dow_next;
        date_reg  <= date_next;
        month_reg <= month_next;
        year_reg  <= year_next;
      end else if (wr_go && !locked) begin                          // [R6]
        case (addr_q)
          ruc_pkg::OFS_SEC:     sec_reg   <= HWDATA[7:0];
          ruc_pkg::OFS_ALM_SEC: asec_reg  <= HWDATA[7:0];
          ruc_pkg::OFS_MIN:     min_reg   <= HWDATA[7:0];
          ruc_pkg::OFS_ALM_MIN: amin_reg  <= HWDATA[7:0];
          ruc_pkg::OFS_HOUR:    hour_reg  <= HWDATA[7:0];
          ruc_pkg::OFS_ALM_HR:  ahour_reg <= HWDATA[7:0];
          ruc_pkg::OFS_DOW:     dow_reg   <= HWDATA[7:0];
          ruc_pkg::OFS_DATE:    date_reg  <= HWDATA[7:0];
          ruc_pkg::OFS_MONTH:   month_reg <= HWDATA[7:0];
          ruc_pkg::OFS_YEAR:    year_reg  <= HWDATA[7:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // event flags, cleared by reading the flag register; a set wins
  // ----------------------------------------------------------------------
  assign irq_next = (uf_reg && uie_reg) || (af_reg && aie_reg) || (periodic_flag_reg && pie_reg);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      uf_reg <= 1'b0;
      af_reg <= 1'b0;
      periodic_flag_reg <= 1'b0;
      IRQ_N  <= 1'b1;
    end else if (CLK_EN) begin
      uf_reg <= do_update || (uf_reg && !(rd_go && addr_q == ruc_pkg::OFS_FLAGS)); // [R9]
      af_reg <= (do_update && alarm_hit)
                || (af_reg && !(rd_go && addr_q == ruc_pkg::OFS_FLAGS));  // [R20]
      periodic_flag_reg <= pi_pulse
                           || (periodic_flag_reg && !(rd_go && addr_q == ruc_pkg::OFS_FLAGS));
      IRQ_N  <= !irq_next;                                          // [R9] [R20]
    end
  end

endmodule : ruc_top

// >>> hdl/ruc_pkg.sv
// What this block does
// R1: one update cycle per second while base valid, chain running and set bit clear
// R2: set bit high aborts a running update and blocks new ones
// R3: update bumps seconds, carrying through minutes, hours, day, date, month, year
// R4: alarm fires when hour, minute, second each match or hold wildcard 11xxxxxx
// R5: update lasts 248 us on megahertz bases, 1984 us on 32.768 kHz base
// R6: time, calendar and alarm bytes are off the bus during update
// R7: update-in-progress flag rises 244 us before update, drops at its end
// R8: software finishes time reads within 244 us of seeing flag at zero
// R9: with update interrupt enabled, every update end raises the interrupt
// R10: software clears interrupt summary flag before leaving its handler
// R11: periodic-interrupt readers finish within half interval plus pre-update time
// R12: with chip not selected, bus inputs are ignored and change nothing
// R13: time base 4.194304 MHz, 1.048576 MHz or 32.768 kHz chosen by divider field
// R14: clock out is time base undivided when select high, divided by four when low
// R15: square wave takes one of 15 taps of the 22 stages, chosen by rate field
// R16: square wave output gated by enable bit in second control register
// R17: divider field 000, 001, 010 select bases; 110, 111 hold chain in reset
// R18: first update comes exactly one second after chain leaves reset
// R19: writing set bit high blocks updates then clears the in-progress flag
// R20: alarm match sets alarm flag; interrupt only when alarm enable set
package ruc_pkg;

  // ----------------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------------
  localparam logic [5:0] OFS_SEC     = 6'h00;
  localparam logic [5:0] OFS_ALM_SEC = 6'h04;
  localparam logic [5:0] OFS_MIN     = 6'h08;
  localparam logic [5:0] OFS_ALM_MIN = 6'h0c;
  localparam logic [5:0] OFS_HOUR    = 6'h10;
  localparam logic [5:0] OFS_ALM_HR  = 6'h14;
  localparam logic [5:0] OFS_DOW     = 6'h18;
  localparam logic [5:0] OFS_DATE    = 6'h1c;
  localparam logic [5:0] OFS_MONTH   = 6'h20;
  localparam logic [5:0] OFS_YEAR    = 6'h24;
  localparam logic [5:0] OFS_CTRL_A  = 6'h28;
  localparam logic [5:0] OFS_CTRL_B  = 6'h2c;
  localparam logic [5:0] OFS_FLAGS   = 6'h30;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int A_UPDATE_IN_PROGRESS_FLAG = 7;
  localparam int A_DV_LO = 4;
  localparam int B_SET = 7;
  localparam int B_PIE = 6;
  localparam int B_AIE = 5;
  localparam int B_UIE = 4;
  localparam int B_SQWE = 3;
  localparam int C_IRQ_SUMMARY_FLAG = 7;
  localparam int C_PERIODIC_FLAG = 6;
  localparam int C_AF = 5;
  localparam int C_UF = 4;

  // ----------------------------------------------------------------------
  // divider field codes and reset values
  // ----------------------------------------------------------------------
  localparam logic [2:0] DV_4M    = 3'h0;
  localparam logic [2:0] DV_1M    = 3'h1;
  localparam logic [2:0] DV_32K   = 3'h2;
  localparam logic [1:0] DV_HOLD  = 2'h3;                 // upper two bits 11 hold reset
  localparam logic [2:0] DV_RST_VALUE = 3'h6;
  localparam logic [3:0] RATE_RST_VALUE = 4'h0;
  localparam logic [7:0] DATE_RST_VALUE = 8'h01;
  localparam int CHAIN_STAGES = 22;
  localparam int TAP_OFFSET = 5;                          // tap bit = rate + offset
  localparam int TAP_SLOW_OFFSET = 12;                    // rates 1,2 on 32.768 kHz

  // ----------------------------------------------------------------------
  // times
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PRE_UPDATE_TIME_US = 244;
  localparam int UPDATE_DURATION_FAST_US = 248;
  localparam int UPDATE_DURATION_SLOW_US = 1984;
  localparam int PRE_UPDATE_CYCLES = PRE_UPDATE_TIME_US * CLK_MHZ;
  localparam int UPDATE_FAST_CYCLES = UPDATE_DURATION_FAST_US * CLK_MHZ;
  localparam int UPDATE_SLOW_CYCLES = UPDATE_DURATION_SLOW_US * CLK_MHZ;

  // ----------------------------------------------------------------------
  // update sequencer states, gray along idle, pre, update
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    UPD_IDLE = 2'b00,
    UPD_PRE  = 2'b01,
    UPD_RUN  = 2'b11
  } ruc_state_t;

endpackage : ruc_pkg

// >>> hdl/ruc_divider.sv
`timescale 1ns/1ns
module ruc_divider (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       en,
  input  wire logic       tb_in,
  input  wire logic [2:0] dv,
  input  wire logic [3:0] rate,
  input  wire logic       sqwe,
  input  wire logic       clock_out_divide_select,
  output logic            tick,
  output logic            pi_pulse,
  output logic            square_wave_pin,
  output logic            clock_out_pin
);

  logic [ruc_pkg::CHAIN_STAGES-1:0] chain_reg;
  logic [ruc_pkg::CHAIN_STAGES:0]   sum;
  logic [ruc_pkg::CHAIN_STAGES-1:0] step;
  logic                             tb_q;
  logic                             tb_edge;
  logic                             valid;
  logic                             hold;
  logic [1:0]                       div4_reg;
  logic [4:0]                       tap;
  logic                             tap_bit;
  logic                             tap_q;

  // ----------------------------------------------------------------------
  // chain control
  // ----------------------------------------------------------------------
  // lower stages are bypassed so every base lands on the same 1 hz carry
  assign valid   = (dv == ruc_pkg::DV_4M) || (dv == ruc_pkg::DV_1M)
                   || (dv == ruc_pkg::DV_32K);                      // [R13] [R17]
  assign hold    = (dv[2:1] == ruc_pkg::DV_HOLD);                   // [R17]
  assign step    = (dv == ruc_pkg::DV_1M)  ? 22'h000004 :
                   (dv == ruc_pkg::DV_32K) ? 22'h000080 : 22'h000001;
  assign sum     = {1'b0, chain_reg} + {1'b0, step};
  assign tb_edge = tb_in & ~tb_q;
  assign tap     = (dv == ruc_pkg::DV_32K && rate < 4'h3)
                   ? 5'(rate + ruc_pkg::TAP_SLOW_OFFSET)
                   : 5'(rate + ruc_pkg::TAP_OFFSET);                // [R15]
  assign tap_bit = (rate != 4'h0) && chain_reg[tap];

  // time base sampling and the divide-by-four for clock out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tb_q     <= 1'b0;
      div4_reg <= 2'h0;
      clock_out_pin <= 1'b0;
    end else if (en) begin
      tb_q <= tb_in;
      if (tb_edge) begin
        div4_reg <= div4_reg + 2'h1;
      end
      clock_out_pin <= clock_out_divide_select ? tb_q : div4_reg[1]; // [R14]
    end
  end

  // divider chain, cleared while held so the first carry is one second out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chain_reg <= '0;
      tick      <= 1'b0;
    end else if (en) begin
      tick <= 1'b0;
      if (hold) begin
        chain_reg <= '0;                                            // [R18]
      end else if (valid && tb_edge) begin
        chain_reg <= sum[ruc_pkg::CHAIN_STAGES-1:0];
        tick      <= sum[ruc_pkg::CHAIN_STAGES];
      end
    end
  end

  // square wave tap and periodic edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_q    <= 1'b0;
      pi_pulse <= 1'b0;
      square_wave_pin <= 1'b0;
    end else if (en) begin
      tap_q    <= tap_bit;
      pi_pulse <= tap_bit & ~tap_q;
      square_wave_pin <= sqwe & tap_bit;                            // [R16]
    end
  end

endmodule : ruc_divider

// >>> verification/ruc_osc_model.sv
`timescale 1ns/1ns
// ----
// time base source
// ----
module ruc_osc_model #(
  parameter int HI = 2,
  parameter int LO = 1
) (
  input  wire logic clk,
  input  wire logic rst,
  output logic      tb_out
);
  int cnt;
  // free running wave, whole clock cycles per level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      tb_out <= 1'b0;
    end else if (cnt >= (tb_out ? HI : LO) - 1) begin
      cnt <= 0;
      tb_out <= ~tb_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : ruc_osc_model

// >>> verification/ruc_top_assertions.sv
`timescale 1ns/1ns
// ----
// port checks
// ----
module ruc_checker #(
  parameter int PRE_CYC      = 8,
  parameter int UPD_FAST_CYC = 10,
  parameter int UPD_SLOW_CYC = 20
) (
  input wire logic        MCLK,
  input wire logic        RST,
  input wire logic        CLK_EN,
  input wire logic        HSEL,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        TIME_BASE_INPUT,
  input wire logic        CLOCK_OUT_DIVIDE_SELECT,
  input wire logic        CLOCK_OUT_PIN,
  input wire logic        SQUARE_WAVE_PIN,
  input wire logic        IRQ_N
);
  logic taken;
  // request accepted at this edge
  assign taken = HSEL && HREADY && HTRANS[1] && HREADYOUT && CLK_EN;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  a_resp_okay: assert property (HRESP == 1'b0) else $error("resp not okay");
  a_taken_wait: assert property (taken |=> !HREADYOUT ##1 HREADYOUT)
    else $error("wait state wrong");
  a_idle_ready: assert property (HREADYOUT && !taken |=> HREADYOUT)
    else $error("spurious wait");
  a_rdata_upper: assert property (HRDATA[31:8] == 24'h0) else $error("upper bits set");
  a_rdata_hold: assert property ($past(HREADYOUT) |-> $stable(HRDATA))
    else $error("read data moved");
  a_reset_vals: assert property ($fell(RST) |-> HREADYOUT && IRQ_N && !SQUARE_WAVE_PIN)
    else $error("bad reset state");
  a_clkout_copy: assert property (CLOCK_OUT_DIVIDE_SELECT && !$past(RST) && !$past(RST, 2)
    && $past(CLOCK_OUT_DIVIDE_SELECT) |-> CLOCK_OUT_PIN == $past(TIME_BASE_INPUT, 2))
    else $error("clock out not base");
  a_irq_release: assert property ($rose(IRQ_N) |-> !$past(HREADYOUT, 2))
    else $error("irq dropped without access");
  a_wait_short: assert property (!HREADYOUT |=> HREADYOUT) else $error("long wait");
  c_write: cover property (taken && HWRITE);
  c_read: cover property (taken && !HWRITE);
  c_irq: cover property ($fell(IRQ_N));
endmodule : ruc_checker
bind ruc_top ruc_checker #(.PRE_CYC(PRE_CYC), .UPD_FAST_CYC(UPD_FAST_CYC),
  .UPD_SLOW_CYC(UPD_SLOW_CYC)) u_chk (.MCLK, .RST, .CLK_EN, .HSEL, .HTRANS, .HWRITE,
  .HREADY, .HRDATA, .HREADYOUT, .HRESP, .TIME_BASE_INPUT, .CLOCK_OUT_DIVIDE_SELECT,
  .CLOCK_OUT_PIN, .SQUARE_WAVE_PIN, .IRQ_N);

// >>> verification/testbench.sv
`timescale 1ns/1ns
// ----
// bench
// ----
module testbench;
  logic        MCLK = 1'b0;
  logic        RST = 1'b1;
  logic        HSEL = 1'b0;
  logic        HWRITE = 1'b0;
  logic [1:0]  HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  logic [31:0] HRDATA;
  logic        HREADYOUT, HRESP, BASE, CK_OUT, SQ_OUT, IRQ_N;
  logic        sel_en = 1'b1;
  logic        ck_sel = 1'b1;
  logic [31:0] r;
  int          miscompares = 0;
  int          tests_run = 0;
  int          n_tgl;
  time         t0;
  // clock and device under test
  always #5 MCLK = ~MCLK;
  ruc_top #(.PRE_CYC(8), .UPD_FAST_CYC(10), .UPD_SLOW_CYC(20)) dut (.MCLK(MCLK), .RST(RST),
    .CLK_EN(1'b1), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
    .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .TIME_BASE_INPUT(BASE), .CLOCK_OUT_DIVIDE_SELECT(ck_sel),
    .CLOCK_OUT_PIN(CK_OUT), .SQUARE_WAVE_PIN(SQ_OUT), .IRQ_N(IRQ_N));
  ruc_osc_model u_osc (.clk(MCLK), .rst(RST), .tb_out(BASE));
  task automatic final_report();
    $display("compared %0d, bad %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 99);
    if (n >= 99) miscompares++;
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge MCLK);
    HSEL   <= sel_en;
    HTRANS <= 2'h2;
    HADDR  <= {26'h0, a};
    HWRITE <= w;
    wait_rdy();
    HTRANS <= 2'h0;
    HWDATA <= {24'h0, d};
    wait_rdy();
    r = HRDATA;
  endtask : xfer
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(r, {24'h0, e});
  endtask : rd
  // count level changes of clock out or square wave over 120 clock cycles
  task automatic count_tgl(input logic sq, output int n);
    logic p;
    n = 0;
    p = sq ? SQ_OUT : CK_OUT;
    repeat (120) begin
      @(posedge MCLK);
      if ((sq ? SQ_OUT : CK_OUT) !== p) n++;
      p = sq ? SQ_OUT : CK_OUT;
    end
  endtask : count_tgl
  // watchdog at 1.2 ms on a run of about one simulated millisecond
  initial begin
    #1200000;
    miscompares++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    rd(ruc_pkg::OFS_CTRL_A, 8'h60);
    rd(ruc_pkg::OFS_FLAGS, 8'h00);
    chk({31'h0, SQ_OUT}, 32'h0);
    $display("test reset done");
    xfer(1'b1, ruc_pkg::OFS_SEC, 8'h3b);
    xfer(1'b1, ruc_pkg::OFS_MIN, 8'h3b);
    xfer(1'b1, ruc_pkg::OFS_HOUR, 8'h17);
    xfer(1'b1, ruc_pkg::OFS_ALM_SEC, 8'hc0);
    xfer(1'b1, ruc_pkg::OFS_ALM_MIN, 8'hc0);
    xfer(1'b1, ruc_pkg::OFS_ALM_HR, 8'hc0);
    xfer(1'b1, ruc_pkg::OFS_CTRL_B, 8'h30);
    xfer(1'b1, ruc_pkg::OFS_CTRL_A, 8'h20);
    t0 = $time;
    r = 32'h0;
    for (int i = 0; i < 40000 && r[7] !== 1'b1; i++) xfer(1'b0, ruc_pkg::OFS_CTRL_A, 8'h00);
    chk({31'h0, ($time - t0) >= 982950 && ($time - t0) <= 983250}, 32'h1);
    repeat (4) @(posedge MCLK);
    rd(ruc_pkg::OFS_SEC, 8'h00);
    repeat (30) @(posedge MCLK);
    rd(ruc_pkg::OFS_CTRL_A, 8'h20);
    chk({31'h0, IRQ_N}, 32'h0);
    rd(ruc_pkg::OFS_FLAGS, 8'hb0);
    @(posedge MCLK);
    chk({31'h0, IRQ_N}, 32'h1);
    rd(ruc_pkg::OFS_HOUR, 8'h00);
    rd(ruc_pkg::OFS_DOW, 8'h02);
    rd(ruc_pkg::OFS_DATE, 8'h02);
    $display("test update done");
    xfer(1'b1, ruc_pkg::OFS_CTRL_B, 8'h80);
    rd(ruc_pkg::OFS_CTRL_A, 8'h20);
    xfer(1'b1, ruc_pkg::OFS_SEC, 8'h05);
    rd(ruc_pkg::OFS_SEC, 8'h05);
    sel_en = 1'b0;
    xfer(1'b1, ruc_pkg::OFS_SEC, 8'h11);
    sel_en = 1'b1;
    rd(ruc_pkg::OFS_SEC, 8'h05);
    rd(6'h3c, 8'h00);
    $display("test set and select done");
    count_tgl(1'b0, n_tgl);
    chk(n_tgl, 32'h50);
    ck_sel <= 1'b0;
    repeat (8) @(posedge MCLK);
    count_tgl(1'b0, n_tgl);
    chk(n_tgl, 32'h14);
    xfer(1'b1, ruc_pkg::OFS_CTRL_B, 8'h88);
    xfer(1'b1, ruc_pkg::OFS_CTRL_A, 8'h23);
    repeat (8) @(posedge MCLK);
    count_tgl(1'b1, n_tgl);
    chk(n_tgl, 32'h14);
    rd(ruc_pkg::OFS_FLAGS, 8'h40);
    $display("test clock outputs done");
    final_report();
  end
endmodule : testbench
